// >>> src/rps_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (RULE_01) up-order code 00..11 enables a rail at step one..four
// (RULE_02) up-order register: pos gate 7:6, pos source 5:4, neg gate 3:2, neg source 1:0
// (RULE_03) up-order resets to neg source, neg gate, pos source, pos gate
// (RULE_04) down-order code 00..11 disables a rail at step one..four
// (RULE_05) down-order register uses the same field layout as up-order
// (RULE_06) down-order resets to pos gate, pos source, neg source, neg gate
// (RULE_07) first up step waits 3/6/9/12 ms after negative power good rises
// (RULE_08) up step one to two waits 3/6/9/12 ms per bits 3:2
// (RULE_09) up step two to three waits 3/6/9/12 ms per bits 5:4
// (RULE_10) up step three to four waits 3/6/9/12 ms per bits 7:6
// (RULE_11) first down step waits 3 or 6 ms after wake goes low
// (RULE_12) down intervals 6/12/24/48 ms, times 1 or 16 by scale bit
// (RULE_13) steps go strictly ascending; rails sharing a step switch together
// (RULE_14) all fields read/write; new values apply at the next sequence
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int CYCLES_PER_MS = rps_pkg::CYCLES_PER_MS_DEF
) (
  input  wire logic                 clock,       // 200 MHz system clock
  input  wire logic                 srst,        // synchronous reset, high
  input  wire rps_pkg::rps_bus_req_t bus_req,    // register strobes, address, data
  output logic [rps_pkg::DATA_W-1:0] rdata,      // read data, cycle after rd
  input  wire logic                 wake_request_input,       // wake pin
  input  wire logic                 neg_converter_power_good, // pin
  output logic                      neg_converter_enable,     // starts negative converter
  output rps_pkg::rps_rails_t       rails,       // rail enables
  output rps_pkg::rps_steps_t       steps        // one-cycle step strobes
);
  import rps_pkg::*;

  rps_state_t          state_reg;
  logic [1:0]          step_reg;
  logic [DATA_W-1:0]   power_up_order_reg, power_up_delays_reg;
  logic [DATA_W-1:0]   power_down_order_reg, power_down_delays_reg;
  logic [DATA_W-1:0]   up_order_snap, up_delays_snap;
  logic [DATA_W-1:0]   dn_order_snap, dn_delays_snap;
  logic [NUM_RAILS-1:0] rails_reg;
  logic [NUM_STEPS-1:0] steps_reg;
  logic                issued_up_reg, issued_dn_reg;
  logic [1:0]          issued_idx_reg;
  logic                wake_s, pg_s, pg_d_reg, pg_rise;
  logic                tmr_load, tmr_done;
  logic [MS_W-1:0]     tmr_ms, ms_left;
  logic                fire_up, fire_dn;

  if (CYCLES_PER_MS < 2) begin : g_bad_cpm
    $error("CYCLES_PER_MS too small");
  end

  // ----------------------------------------------------------------
  // delay decode
  // ----------------------------------------------------------------
  function automatic logic [MS_W-1:0] up_ms(input logic [1:0] code);
    up_ms = MS_W'(UP_UNIT_MS * (int'(code) + 1));
  endfunction
  function automatic logic [MS_W-1:0] dn_ms(input logic [1:0] code, input logic scale);
    dn_ms = MS_W'((DN_BASE_MS << code) * (scale ? DN_SCALE_MUL : 1));
  endfunction
  function automatic logic [MS_W-1:0] dn_first_ms(input logic long_sel);
    dn_first_ms = long_sel ? MS_W'(DN_FIRST_LONG_MS) : MS_W'(DN_FIRST_SHORT_MS);
  endfunction
  // rails whose order field names the given step
  function automatic logic [NUM_RAILS-1:0] rails_at(input logic [DATA_W-1:0] ord,
                                                    input logic [1:0] idx);
    rails_at = '0;
    for (int r = 0; r < NUM_RAILS; r++) begin
      rails_at[r] = (ord[r*FIELD_W +: FIELD_W] == idx);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and timebase
  // ----------------------------------------------------------------
  rps_sync3 u_sync_wake (
    .clock    (clock),
    .srst     (srst),
    .async_in (wake_request_input),
    .clean    (wake_s)
  );
  rps_sync3 u_sync_pg (
    .clock    (clock),
    .srst     (srst),
    .async_in (neg_converter_power_good),
    .clean    (pg_s)
  );
  rps_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS),
    .MS_W          (MS_W)
  ) u_timer (
    .clock   (clock),
    .srst    (srst),
    .load    (tmr_load),
    .load_ms (tmr_ms),
    .ms_left (ms_left),
    .done    (tmr_done)
  );

  // power-good edge, taken from the filtered level only
  always_ff @(posedge clock) begin
    if (srst) begin
      pg_d_reg <= 1'b0;
    end else begin
      pg_d_reg <= pg_s;
    end
  end
  assign pg_rise = pg_s & ~pg_d_reg;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // software copies; the sequence runs from snapshots, except the first power-down delay, read from power_down_delays_reg
  always_ff @(posedge clock) begin
    if (srst) begin
      power_up_order_reg    <= RST_UP_ORDER;   // see RULE_03
      power_up_delays_reg   <= RST_UP_DELAYS;
      power_down_order_reg  <= RST_DN_ORDER;   // see RULE_06
      power_down_delays_reg <= RST_DN_DELAYS;
    end else if (bus_req.wr) begin
      case (bus_req.addr)  // see RULE_14
        ADDR_UP_ORDER:  power_up_order_reg    <= bus_req.wdata;  // see RULE_02
        ADDR_UP_DELAYS: power_up_delays_reg   <= bus_req.wdata;
        ADDR_DN_ORDER:  power_down_order_reg  <= bus_req.wdata;  // see RULE_05
        ADDR_DN_DELAYS: power_down_delays_reg <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= '0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_UP_ORDER:  rdata <= power_up_order_reg;
        ADDR_UP_DELAYS: rdata <= power_up_delays_reg;
        ADDR_DN_ORDER:  rdata <= power_down_order_reg;
        ADDR_DN_DELAYS: rdata <= power_down_delays_reg;
        ADDR_STATUS: begin
          rdata <= '0;
          rdata[ST_RAILS_LSB +: NUM_RAILS] <= rails_reg;
          rdata[ST_STEP_LSB +: 2]          <= step_reg;
          rdata[ST_BUSY_BIT] <= (state_reg != S_IDLE) && (state_reg != S_ON);
          rdata[ST_PG_BIT]   <= pg_s;
        end
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  assign fire_up = (state_reg == S_UP_WAIT) && tmr_done && wake_s;
  assign fire_dn = (state_reg == S_DN_WAIT) && tmr_done;

  // timer load requests, decoded from the same conditions as the fsm
  always_comb begin
    tmr_load = 1'b0;
    tmr_ms   = '0;
    case (state_reg)
      S_WAIT_PG: begin
        if (wake_s && pg_rise) begin
          tmr_load = 1'b1;
          tmr_ms   = up_ms(up_delays_snap[0 +: FIELD_W]);  // see RULE_07
        end
      end
      S_UP_WAIT: begin
        if (!wake_s) begin
          tmr_load = 1'b1;
          tmr_ms   = dn_first_ms(power_down_delays_reg[DN_FIRST_BIT]);  // see RULE_11
        end else if (fire_up && step_reg != 2'(NUM_STEPS - 1)) begin
          // see RULE_08, see RULE_09, see RULE_10
          tmr_load = 1'b1;
          tmr_ms   = up_ms(up_delays_snap[(int'(step_reg) + 1) * FIELD_W +: FIELD_W]);
        end
      end
      S_ON: begin
        if (!wake_s) begin
          tmr_load = 1'b1;
          tmr_ms   = dn_first_ms(power_down_delays_reg[DN_FIRST_BIT]);  // see RULE_11
        end
      end
      S_DN_WAIT: begin
        if (fire_dn && step_reg != 2'(NUM_STEPS - 1)) begin
          tmr_load = 1'b1;  // see RULE_12
          tmr_ms   = dn_ms(dn_delays_snap[(int'(step_reg) + 1) * FIELD_W +: FIELD_W],
                           dn_delays_snap[DN_SCALE_BIT]);
        end
      end
      default: ;
    endcase
  end

  // main state machine; a wake drop mid power-up turns straight into power-down
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg            <= S_IDLE;
      step_reg             <= '0;
      neg_converter_enable <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (wake_s) begin
            neg_converter_enable <= 1'b1;
            state_reg            <= S_WAIT_PG;
          end
        end
        S_WAIT_PG: begin
          if (!wake_s) begin
            neg_converter_enable <= 1'b0;
            state_reg            <= S_IDLE;
          end else if (pg_rise) begin
            step_reg  <= '0;
            state_reg <= S_UP_WAIT;
          end
        end
        S_UP_WAIT: begin
          if (!wake_s) begin
            step_reg  <= '0;
            state_reg <= S_DN_WAIT;
          end else if (fire_up) begin
            // strictly ascending steps
            if (step_reg == 2'(NUM_STEPS - 1)) begin
              state_reg <= S_ON;
            end else begin
              step_reg <= step_reg + 2'd1;  // see RULE_13
            end
          end
        end
        S_ON: begin
          if (!wake_s) begin
            step_reg  <= '0;
            state_reg <= S_DN_WAIT;
          end
        end
        S_DN_WAIT: begin
          // a wake return is ignored until the fourth down step has fired
          if (fire_dn) begin
            if (step_reg == 2'(NUM_STEPS - 1)) begin
              neg_converter_enable <= 1'b0;
              state_reg            <= S_IDLE;
            end else begin
              step_reg <= step_reg + 2'd1;  // see RULE_13
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // snapshots freeze settings for the whole sequence
  always_ff @(posedge clock) begin
    if (srst) begin
      up_order_snap  <= RST_UP_ORDER;
      up_delays_snap <= RST_UP_DELAYS;
      dn_order_snap  <= RST_DN_ORDER;
      dn_delays_snap <= RST_DN_DELAYS;
    end else begin
      if (state_reg == S_IDLE && wake_s) begin
        up_order_snap  <= power_up_order_reg;   // see RULE_14
        up_delays_snap <= power_up_delays_reg;
      end
      if ((state_reg == S_UP_WAIT || state_reg == S_ON) && !wake_s) begin
        dn_order_snap  <= power_down_order_reg; // see RULE_14
        dn_delays_snap <= power_down_delays_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // rail and strobe outputs
  // ----------------------------------------------------------------
  for (genvar r = 0; r < NUM_RAILS; r++) begin : g_rail
    // every rail matching the step switches on the same edge
    always_ff @(posedge clock) begin
      if (srst) begin
        rails_reg[r] <= 1'b0;
      end else if (fire_up && up_order_snap[r*FIELD_W +: FIELD_W] == step_reg) begin
        rails_reg[r] <= 1'b1;  // see RULE_01, see RULE_13
      end else if (fire_dn && dn_order_snap[r*FIELD_W +: FIELD_W] == step_reg) begin
        rails_reg[r] <= 1'b0;  // see RULE_04, see RULE_13
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      steps_reg      <= '0;
      issued_up_reg  <= 1'b0;
      issued_dn_reg  <= 1'b0;
      issued_idx_reg <= '0;
    end else begin
      steps_reg      <= (fire_up || fire_dn) ? NUM_STEPS'(1) << step_reg : '0;
      issued_up_reg  <= fire_up;
      issued_dn_reg  <= fire_dn;
      issued_idx_reg <= step_reg;
    end
  end

  assign rails = rps_rails_t'(rails_reg);
  assign steps = rps_steps_t'(steps_reg);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_pg_to_up;
    state_reg == S_WAIT_PG ##1 state_reg == S_UP_WAIT;
  endsequence
  sequence s_on_to_dn;
    state_reg == S_ON ##1 state_reg == S_DN_WAIT;
  endsequence

  chk_up_first_delay: assert property ( // see RULE_07
    s_pg_to_up |-> ms_left == MS_W'(UP_UNIT_MS * (int'(up_delays_snap[1:0]) + 1)))
    else $error("first power-up delay wrong");
  chk_down_first_delay: assert property ( // see RULE_11
    s_on_to_dn |-> ms_left == (dn_delays_snap[DN_FIRST_BIT] ? MS_W'(DN_FIRST_LONG_MS)
                                                            : MS_W'(DN_FIRST_SHORT_MS)))
    else $error("first power-down delay wrong");
  chk_up_rail_on: assert property ( // see RULE_01
    issued_up_reg |-> (rails_at(up_order_snap, issued_idx_reg) & ~rails_reg) == '0)
    else $error("rail not enabled at its step");
  chk_dn_rail_off: assert property ( // see RULE_04
    issued_dn_reg |-> (rails_at(dn_order_snap, issued_idx_reg) & rails_reg) == '0)
    else $error("rail not disabled at its step");
  chk_step_order: assert property ( // see RULE_13
    (fire_up || fire_dn) && step_reg != 2'(NUM_STEPS - 1) |=>
      step_reg == $past(step_reg) + 2'd1 ##1 (steps_reg == '0) [*1])
    else $error("steps not ascending");
  chk_strobe_onehot: assert property ( // see RULE_13
    (issued_up_reg || issued_dn_reg) |-> steps_reg == NUM_STEPS'(1) << issued_idx_reg)
    else $error("step strobe does not match step");
  chk_up_reset_val: assert property ( // see RULE_03
    $past(srst) |-> power_up_order_reg == RST_UP_ORDER)
    else $error("power-up order reset value wrong");
  chk_dn_reset_val: assert property ( // see RULE_06
    $past(srst) |-> power_down_order_reg == RST_DN_ORDER)
    else $error("power-down order reset value wrong");
  chk_read_up_order: assert property ( // see RULE_02
    bus_req.rd && bus_req.addr == ADDR_UP_ORDER |=> rdata == $past(power_up_order_reg))
    else $error("power-up order readback wrong");
  chk_cfg_frozen: assert property ( // see RULE_14
    state_reg == S_UP_WAIT ##1 state_reg == S_UP_WAIT |-> $stable(up_order_snap))
    else $error("snapshot changed mid sequence");
endmodule // rps_sequencer
`default_nettype wire

// >>> shared/rps_pkg.sv
`default_nettype none
package rps_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_UP_ORDER  = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_UP_DELAYS = 8'h0A;
  localparam logic [ADDR_W-1:0] ADDR_DN_ORDER  = 8'h0B;
  localparam logic [ADDR_W-1:0] ADDR_DN_DELAYS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h10;
  localparam logic [DATA_W-1:0] RST_UP_ORDER   = 8'hE4;
  localparam logic [DATA_W-1:0] RST_UP_DELAYS  = 8'h55;
  localparam logic [DATA_W-1:0] RST_DN_ORDER   = 8'h1E;
  localparam logic [DATA_W-1:0] RST_DN_DELAYS  = 8'hE0;
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int NUM_RAILS = 4;   // bit 3 pos gate .. bit 0 neg source
  localparam int NUM_STEPS = 4;
  localparam int FIELD_W   = 2;
  localparam int DN_SCALE_BIT = 0;
  localparam int DN_FIRST_BIT = 1;
  localparam int ST_RAILS_LSB = 0;
  localparam int ST_STEP_LSB  = 4;
  localparam int ST_BUSY_BIT  = 6;
  localparam int ST_PG_BIT    = 7;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 5;
  localparam int MS_NS             = 1000000;
  localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int UP_UNIT_MS        = 3;
  localparam int DN_FIRST_SHORT_MS = 3;
  localparam int DN_FIRST_LONG_MS  = 6;
  localparam int DN_BASE_MS        = 6;
  localparam int DN_SCALE_MUL      = 16;
  localparam int MS_W              = 10;  // holds 48 ms x 16
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_WAIT_PG = 3'h1,
    S_UP_WAIT = 3'h3,
    S_ON      = 3'h2,
    S_DN_WAIT = 3'h6
  } rps_state_t;
  typedef struct packed {
    logic positive_gate_rail;
    logic positive_source_rail;
    logic negative_gate_rail;
    logic negative_source_rail;
  } rps_rails_t;
  typedef struct packed {
    logic sequence_step_four;
    logic sequence_step_three;
    logic sequence_step_two;
    logic sequence_step_one;
  } rps_steps_t;
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rps_bus_req_t;
endpackage
`default_nettype wire

// >>> src/rps_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module rps_sync3 (
  input  wire logic clock,  // system clock
  input  wire logic srst,   // synchronous reset
  input  wire logic async_in, // pin level
  output logic      clean     // filtered level
);
  logic f1_reg, f2_reg, f3_reg;
  // ----------------------------------------------------------------
  // three-stage capture, second and third must agree
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      f1_reg <= 1'b0;
      f2_reg <= 1'b0;
      f3_reg <= 1'b0;
      clean  <= 1'b0;
    end else begin
      f1_reg <= async_in;
      f2_reg <= f1_reg;
      f3_reg <= f2_reg;
      // agreement filter stops a single metastable sample leaking out
      if (f2_reg == f3_reg) begin
        clean <= f3_reg;
      end
    end
  end
endmodule // rps_sync3
`default_nettype wire

// >>> src/rps_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
module rps_ms_timer #(
  parameter int CYCLES_PER_MS = 200000,
  parameter int MS_W          = 10
) (
  input  wire logic            clock,   // system clock
  input  wire logic            srst,    // synchronous reset
  input  wire logic            load,    // restart with load_ms
  input  wire logic [MS_W-1:0] load_ms, // delay in milliseconds
  output logic      [MS_W-1:0] ms_left, // milliseconds still to run
  output logic                 done     // one-cycle pulse at expiry
);
  localparam int PW = $clog2(CYCLES_PER_MS);
  localparam logic [PW-1:0] PRES_MAX = PW'(CYCLES_PER_MS - 1);
  logic [PW-1:0] pres_reg;
  if (CYCLES_PER_MS < 2) begin : g_bad_cpm
    $error("CYCLES_PER_MS must be at least 2");
  end
  // ----------------------------------------------------------------
  // prescaler restarts on load so each delay is exact in cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      pres_reg <= '0;
      ms_left  <= '0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        pres_reg <= PRES_MAX;
        ms_left  <= load_ms;
      end else if (ms_left != '0) begin
        if (pres_reg == '0) begin
          pres_reg <= PRES_MAX;
          ms_left  <= ms_left - MS_W'(1);
          done     <= (ms_left == MS_W'(1));
        end else begin
          pres_reg <= pres_reg - PW'(1);
        end
      end
    end
  end
endmodule // rps_ms_timer
`default_nettype wire

// >>> verification/rps_neg_conv_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// negative converter: power good follows enable after a start-up
// ------------------------------------------------------------
module rps_neg_conv_model (
  input  wire logic clock,      // system clock
  input  wire logic enable,     // converter enable from the sequencer
  input  wire logic slow,       // selects the long start-up
  output logic      power_good  // good flag back to the sequencer
);
  int   cnt  = 0;
  logic pg_q = 1'b0;
  assign power_good = pg_q;
  // good drops at once on disable, like a real converter losing regulation
  always @(posedge clock) begin
    if (!enable) begin
      cnt  <= 0;
      pg_q <= 1'b0;
    end else if (cnt == (slow ? 40 : 3)) begin
      pg_q <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // rps_neg_conv_model
`default_nettype wire

// >>> verification/rps_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rps_sequencer_tb_top;
  import rps_pkg::*;
  // ------------------------------------------------------------
  // clock, design and converter
  // ------------------------------------------------------------
  localparam int CPM = 4;  // short millisecond keeps the run brief
  logic              clock   = 1'b0;
  logic              srst    = 1'b1;
  rps_bus_req_t      bus_req = '0;
  logic [DATA_W-1:0] rdata;
  logic              wake    = 1'b0;
  logic              slow    = 1'b0;
  logic              pg;
  logic              nce;
  rps_rails_t        rails;
  rps_steps_t        steps;
  int                fail_count = 0;
  int                compares   = 0;
  int                cyc        = 0;
  int                pg_rise    = 0;
  logic              pg_d       = 1'b0;
  logic [31:0]       seed       = 32'h80EE;
  int                st_q[$];
  int                cy_q[$];
  logic [3:0]        rl_q[$];

  always #2.5 clock = ~clock;

  rps_sequencer #(.CYCLES_PER_MS(CPM)) DUT (.clock(clock), .srst(srst), .bus_req(bus_req), .rdata(rdata),
    .wake_request_input(wake), .neg_converter_power_good(pg), .neg_converter_enable(nce),
    .rails(rails), .steps(steps));
  rps_neg_conv_model PART (.clock(clock), .enable(nce), .slow(slow), .power_good(pg));

  // every strobe is logged with its cycle and the rail levels beside it
  always @(posedge clock) begin
    cyc  <= cyc + 1;
    pg_d <= pg;
    if (pg && !pg_d) pg_rise <= cyc;
    if (steps !== 4'h0) begin
      st_q.push_back(steps === 4'h1 ? 0 : steps === 4'h2 ? 1 : steps === 4'h4 ? 2 : steps === 4'h8 ? 3 : 9);
      cy_q.push_back(cyc);
      rl_q.push_back(rails);
    end
  end

  // ------------------------------------------------------------
  // expectations and checks
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] exp_rails(logic [7:0] ord, int k, logic up);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) r[i] = up ? (ord[2*i+:2] <= k) : (ord[2*i+:2] > k);
    return r;
  endfunction
  function automatic int exp_gap(logic up, logic [7:0] dly, int k);
    if (up) return 3 * (int'(dly[2*k+:2]) + 1) * CPM;
    if (k == 0) return (dly[1] ? 6 : 3) * CPM;
    return (6 << dly[2*k+:2]) * (dly[0] ? 16 : 1) * CPM;
  endfunction
  task automatic check_val(logic [7:0] got, logic [7:0] exp, string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // the slack covers pin synchronisers and the strobe register stage
  task automatic check_time(int got, int exp, int slack, string what);
    compares++;
    if (got < exp || got > exp + slack) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s took %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic bus_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask
  task automatic bus_rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
    d = rdata;
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // one full power-up then power-down with the given settings
  // ------------------------------------------------------------
  task automatic run_seq(logic [7:0] uo, logic [7:0] ud, logic [7:0] dn, logic [7:0] dd);
    logic [7:0] v[4];
    logic [7:0] d;
    int         t0;
    int         n;
    logic       wrote;
    v = '{uo, ud, dn, dd};
    for (int i = 0; i < 4; i++) begin
      bus_wr(ADDR_UP_ORDER + 8'(i), v[i]);
      bus_rd(ADDR_UP_ORDER + 8'(i), d);
      check_val(d, v[i], "register readback");
    end
    for (int up = 1; up >= 0; up--) begin
      st_q.delete();
      cy_q.delete();
      rl_q.delete();
      wake <= 1'(up);
      t0 = cyc;
      n  = 0;
      wrote = 1'b0;
      while (st_q.size() < 4 && n < 12000) begin
        @(posedge clock);
        n++;
        // a write mid-sequence must only apply to the next sequence
        if (st_q.size() == 1 && !wrote) begin
          bus_wr(up ? ADDR_UP_ORDER : ADDR_DN_ORDER, up ? ~uo : ~dn);
          wrote = 1'b1;
        end
      end
      if (up == 1) t0 = pg_rise;
      check_val(8'(st_q.size()), 8'h04, "step count");
      for (int k = 0; k < 4 && k < st_q.size(); k++) begin
        check_val(8'(st_q[k]), 8'(k), "step order");
        check_val({4'h0, rl_q[k]}, {4'h0, exp_rails(up ? uo : dn, k, 1'(up))}, "rails");
        check_time(cy_q[k] - (k == 0 ? t0 : cy_q[k-1]), exp_gap(1'(up), up ? ud : dd, k), k == 0 ? 8 : 2,
          "step delay");
      end
      if (up == 1) begin
        check_val({7'h0, nce}, 8'h01, "converter on after power-up");
        bus_rd(ADDR_STATUS, d);
        check_val(d, 8'hBF, "status after power-up");
      end
    end
    repeat (20) @(posedge clock);
    check_val({7'h0, nce}, 8'h00, "converter off after power-down");
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  d;
    logic [31:0] r;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    bus_rd(ADDR_UP_ORDER, d);
    check_val(d, RST_UP_ORDER, "up order reset");
    bus_rd(ADDR_DN_ORDER, d);
    check_val(d, RST_DN_ORDER, "down order reset");
    bus_wr(8'h3C, 8'hA5);
    bus_rd(8'h3C, d);
    check_val(d, 8'h00, "unmapped read");
    // reversed orders with every power-up delay code, then all rails sharing one step
    run_seq(8'h1B, 8'hE4, 8'hE4, 8'hE2);
    slow <= 1'b1;
    run_seq(8'h00, 8'h1B, 8'hFF, 8'h1D);
    // wake dropped while the slow converter is still starting: back to idle
    wake <= 1'b1;
    repeat (12) @(posedge clock);
    check_val({7'h0, nce}, 8'h01, "converter on while waiting");
    wake <= 1'b0;
    repeat (12) @(posedge clock);
    check_val({3'h0, nce, rails}, 8'h00, "wake drop before power good");
    slow <= 1'b0;
    repeat (3) begin
      r = xs();
      run_seq(r[7:0], r[15:8], r[23:16], r[31:24]);
    end
    results();
  end
  // sized for five worst-case sequences with scaled power-down gaps
  initial begin
    repeat (90000) @(posedge clock);
    fail_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    results();
  end
endmodule // rps_sequencer_tb_top
`default_nettype wire
